// [kic_cfg.svh]
`ifndef KIC_CFG_SVH
`define KIC_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define KIC_ADDR_CTRL    8'h00
`define KIC_ADDR_AUXCFG  8'h04
`define KIC_ADDR_MENU    8'h08
`define KIC_ADDR_PARAM   8'h0C
`define KIC_ADDR_STATUS  8'h10
`define KIC_ADDR_LPDLY   8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define KIC_CTRL_ENABLE   0
`define KIC_CTRL_COMM_CFG 1
`define KIC_CTRL_COMM_OK  2
`define KIC_CTRL_ASSOC    3
`define KIC_CTRL_RUN      4
`define KIC_CTRL_ERR_BLK  5
`define KIC_CTRL_EDITABLE 6

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define KIC_CTRL_RST   7'h41
`define KIC_AUXCFG_RST 32'h0A05_0301
`define KIC_LAST_RST   4'h9
`define KIC_LPDLY_RST  16'h03E8

// ---------------------------------------------------------------
// Function codes and fault codes
// ---------------------------------------------------------------
`define KIC_FN_FLOAT   8'h01
`define KIC_FN_SETP2   8'h03
`define KIC_FN_SYSDIS  8'h05
`define KIC_FN_LOWP    8'h0A
`define KIC_FLT_NONE   4'h0
`define KIC_FLT_FLOAT  4'h1
`define KIC_FLT_SYSDIS 4'h3
`define KIC_FLT_LOWP   4'h4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define KIC_CLK_HZ       125000000
`define KIC_CYC_PER_MS   (`KIC_CLK_HZ / 1000)
`define KIC_DEBOUNCE_MS  10
`define KIC_MODE_HOLD_MS 1000
`define KIC_FAST_HOLD_MS 3000
`define KIC_REP_SLOW_MS  250
`define KIC_REP_FAST_MS  50
`define KIC_BLINK_SLOW_MS 500
`define KIC_BLINK_FAST_MS 100

`endif

// [kic_pkg.sv]
package kic_pkg;

  typedef enum logic [1:0] {
    KIC_ED_IDLE = 2'b00,
    KIC_ED_SLOW = 2'b01,
    KIC_ED_FAST = 2'b11
  } kic_edit_st_t;

  typedef enum logic [1:0] {
    KIC_KEY_MODE  = 2'd0,
    KIC_KEY_SET   = 2'd1,
    KIC_KEY_PLUS  = 2'd2,
    KIC_KEY_MINUS = 2'd3
  } kic_key_idx_t;

endpackage

// [kic_key_filter.sv]
`timescale 1ns/1ps

module kic_key_filter #(
  parameter int unsigned DEB_CYC = 1250000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic key_raw,
  output logic      key_level,
  output logic      key_rise,
  output logic      key_fall
);

  localparam int unsigned CW = $clog2(DEB_CYC + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] cnt_reg;
  logic          level_reg;
  logic          rise_reg;
  logic          fall_reg;

  wire differ  = sync2_reg != level_reg;
  wire settled = differ && (cnt_reg == CW'(DEB_CYC - 1));

  // ---------------------------------------------------------------
  // Synchroniser and debounce
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      cnt_reg   <= '0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end else begin
      sync1_reg <= key_raw;
      sync2_reg <= sync1_reg;
      cnt_reg   <= (differ && !settled) ? cnt_reg + 1'b1 : '0; // [R23]
      if (settled) begin
        level_reg <= sync2_reg; // [R23]
      end
      rise_reg  <= settled && sync2_reg;
      fall_reg  <= settled && !sync2_reg;
    end
  end

  assign key_level = level_reg;
  assign key_rise  = rise_reg;
  assign key_fall  = fall_reg;

endmodule

// [kic_panel.sv]
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "kic_cfg.svh"
// Contract
// R1: Short mode press advances cursor to next item of current menu.
// R2: Mode held one second steps cursor back to previous item.
// R3: Set press leaves the current menu to the one above.
// R4: Minus press decrements selected parameter only when editable.
// R5: Plus press increments selected parameter only when editable.
// R6: Holding plus or minus repeats the step automatically.
// R7: After three seconds held, repeat switches to faster rate.
// R8: Every plus or minus step saves the value to non-volatile memory.
// R9: Saving needs no set press; set only exits.
// R10: Power lamp steady when enabled, blinking when disabled.
// R11: Alarm lamp steady while pump blocked by error.
// R12: Comm lamp steady when wireless enabled and working.
// R13: Comm lamp blinks slowly when configured but link faulty.
// R14: Comm lamp blinks fast during association.
// R15: Comm lamp dark when communication not configured.
// R16: Aux input function codes reset to 1, 3, 5 and 10.
// R17: Float-coded input closed blocks pump with float fault code.
// R18: Setpoint-coded input closed selects second auxiliary setpoint.
// R19: Disable-coded input closed blocks pump with disable fault code.
// R20: Low-pressure input closed past delay blocks with low-pressure code.
// R21: Exactly four auxiliary inputs and two relay outputs are used.
// R22: Second relay closes while pump is running.
// R23: Keys are synchronised and debounced before timing starts.
// R24: Every block lights alarm; input-raised block clears on reopen.

module kic_panel #(
  parameter int unsigned DEB_CYC    = `KIC_DEBOUNCE_MS * `KIC_CYC_PER_MS,
  parameter int unsigned MODE_CYC   = `KIC_MODE_HOLD_MS * `KIC_CYC_PER_MS,
  parameter int unsigned FAST_CYC   = `KIC_FAST_HOLD_MS * `KIC_CYC_PER_MS,
  parameter int unsigned RSLOW_CYC  = `KIC_REP_SLOW_MS * `KIC_CYC_PER_MS,
  parameter int unsigned RFAST_CYC  = `KIC_REP_FAST_MS * `KIC_CYC_PER_MS,
  parameter int unsigned BSLOW_CYC  = `KIC_BLINK_SLOW_MS * `KIC_CYC_PER_MS,
  parameter int unsigned BFAST_CYC  = `KIC_BLINK_FAST_MS * `KIC_CYC_PER_MS,
  parameter int unsigned MS_CYC     = `KIC_CYC_PER_MS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        key_mode,
  input  wire logic        key_set,
  input  wire logic        key_plus,
  input  wire logic        key_minus,
  input  wire logic        aux_input_one,
  input  wire logic        aux_input_two,
  input  wire logic        aux_input_three,
  input  wire logic        aux_input_four,
  output logic             led_power,
  output logic             led_alarm,
  output logic             led_comm,
  output logic             relay_output_one,
  output logic             relay_output_two,
  output logic             setpoint_second,
  output logic      [3:0]  fault_code,
  output logic             nv_write_strobe,
  output logic      [15:0] nv_write_data
);

  localparam int unsigned HW = $clog2(FAST_CYC + 1);
  localparam int unsigned RW = $clog2(RSLOW_CYC + 1);
  localparam int unsigned MW = $clog2(MODE_CYC + 1);
  localparam int unsigned BW = $clog2(BSLOW_CYC + 1);
  localparam int unsigned SW = $clog2(MS_CYC + 1);

  function automatic logic fn_hit(input logic [7:0] cfg, input logic [7:0] code);
    fn_hit = cfg == code;
  endfunction

  // ---------------------------------------------------------------
  // Key filters
  // ---------------------------------------------------------------
  wire [3:0] keys_raw = {key_minus, key_plus, key_set, key_mode};
  logic [3:0] k_lvl;
  logic [3:0] k_rise;
  logic [3:0] k_fall;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_key
      kic_key_filter #(.DEB_CYC(DEB_CYC)) u_filt (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .key_raw   (keys_raw[gi]),
        .key_level (k_lvl[gi]),
        .key_rise  (k_rise[gi]),
        .key_fall  (k_fall[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [6:0]  ctrl_reg;
  logic [31:0] auxcfg_reg;
  logic [3:0]  cursor_reg;
  logic [1:0]  level_reg;
  logic [3:0]  last_reg;
  logic [15:0] param_reg;
  logic [15:0] lpdly_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] hrdata_reg;

  wire ahb_go  = hsel && htrans[1] && hready;
  wire wr_ctrl = wr_pend_reg && (wr_addr_reg == `KIC_ADDR_CTRL);
  wire wr_aux  = wr_pend_reg && (wr_addr_reg == `KIC_ADDR_AUXCFG);
  wire wr_menu = wr_pend_reg && (wr_addr_reg == `KIC_ADDR_MENU);
  wire wr_prm  = wr_pend_reg && (wr_addr_reg == `KIC_ADDR_PARAM);
  wire wr_lpd  = wr_pend_reg && (wr_addr_reg == `KIC_ADDR_LPDLY);

  wire enable_sw = ctrl_reg[`KIC_CTRL_ENABLE];
  wire comm_cfg  = ctrl_reg[`KIC_CTRL_COMM_CFG];
  wire comm_ok   = ctrl_reg[`KIC_CTRL_COMM_OK];
  wire assoc     = ctrl_reg[`KIC_CTRL_ASSOC];
  wire pump_run  = ctrl_reg[`KIC_CTRL_RUN];
  wire err_blk   = ctrl_reg[`KIC_CTRL_ERR_BLK];
  wire editable  = ctrl_reg[`KIC_CTRL_EDITABLE];

  // ---------------------------------------------------------------
  // Menu navigation
  // ---------------------------------------------------------------
  logic [MW-1:0] mode_cnt_reg;
  logic          mode_back_reg;

  wire mode_hit  = k_lvl[kic_pkg::KIC_KEY_MODE] && (mode_cnt_reg == MW'(MODE_CYC - 1));
  wire mode_back = mode_hit && !mode_back_reg;                             // [R2]
  wire mode_fwd  = k_fall[kic_pkg::KIC_KEY_MODE] && !mode_back_reg;        // [R1]
  wire set_exit  = k_rise[kic_pkg::KIC_KEY_SET] && (level_reg != 2'd0);    // [R3]
  wire [3:0] cur_inc = (cursor_reg >= last_reg) ? 4'h0 : cursor_reg + 4'h1;
  wire [3:0] cur_dec = (cursor_reg == 4'h0) ? last_reg : cursor_reg - 4'h1;
  wire [3:0] cursor_next = set_exit  ? 4'h0 :
                           mode_back ? cur_dec :                           // [R2]
                           mode_fwd  ? cur_inc : cursor_reg;               // [R1]
  wire [1:0] level_next  = wr_menu  ? hwdata[5:4] :
                           set_exit ? level_reg - 2'd1 : level_reg;        // [R3]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_cnt_reg  <= '0;
      mode_back_reg <= 1'b0;
    end else begin
      mode_cnt_reg  <= (k_lvl[kic_pkg::KIC_KEY_MODE] && !mode_hit) ? mode_cnt_reg + 1'b1 : '0;
      mode_back_reg <= k_lvl[kic_pkg::KIC_KEY_MODE] && (mode_back_reg || mode_hit);
    end
  end

  // ---------------------------------------------------------------
  // Parameter editing with auto-repeat
  // ---------------------------------------------------------------
  kic_pkg::kic_edit_st_t ed_st_reg;
  kic_pkg::kic_edit_st_t ed_st_next;
  logic [HW-1:0] held_reg;
  logic [RW-1:0] rep_reg;

  wire one_edit  = k_lvl[kic_pkg::KIC_KEY_PLUS] ^ k_lvl[kic_pkg::KIC_KEY_MINUS];
  wire go_up     = k_lvl[kic_pkg::KIC_KEY_PLUS];
  wire first_hit = (k_rise[kic_pkg::KIC_KEY_PLUS] && !k_lvl[kic_pkg::KIC_KEY_MINUS]) ||
                   (k_rise[kic_pkg::KIC_KEY_MINUS] && !k_lvl[kic_pkg::KIC_KEY_PLUS]);
  wire [RW-1:0] rep_last = (ed_st_reg == kic_pkg::KIC_ED_FAST) ?
                           RW'(RFAST_CYC - 1) : RW'(RSLOW_CYC - 1);        // [R7]
  wire rep_hit   = (ed_st_reg != kic_pkg::KIC_ED_IDLE) && one_edit &&
                   (rep_reg == rep_last);                                  // [R6]
  wire fast_hit  = (ed_st_reg == kic_pkg::KIC_ED_SLOW) && (held_reg == HW'(FAST_CYC - 1));
  wire step      = ((ed_st_reg == kic_pkg::KIC_ED_IDLE) && first_hit) || rep_hit;
  wire do_edit   = step && editable;                                       // [R4] [R5]
  wire [15:0] prm_up = (param_reg == 16'hFFFF) ? param_reg : param_reg + 16'h0001;
  wire [15:0] prm_dn = (param_reg == 16'h0000) ? param_reg : param_reg - 16'h0001;
  wire [15:0] prm_step = go_up ? prm_up : prm_dn;                          // [R4] [R5]

  always_comb begin
    ed_st_next = ed_st_reg;
    case (ed_st_reg)
      kic_pkg::KIC_ED_IDLE: begin
        if (first_hit) begin
          ed_st_next = kic_pkg::KIC_ED_SLOW;
        end
      end
      kic_pkg::KIC_ED_SLOW: begin
        if (!one_edit) begin
          ed_st_next = kic_pkg::KIC_ED_IDLE;
        end else if (fast_hit) begin
          ed_st_next = kic_pkg::KIC_ED_FAST;                               // [R7]
        end
      end
      kic_pkg::KIC_ED_FAST: begin
        if (!one_edit) begin
          ed_st_next = kic_pkg::KIC_ED_IDLE;
        end
      end
      default: ed_st_next = kic_pkg::KIC_ED_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ed_st_reg <= kic_pkg::KIC_ED_IDLE;
      held_reg  <= '0;
      rep_reg   <= '0;
    end else begin
      ed_st_reg <= ed_st_next;
      held_reg  <= (ed_st_next == kic_pkg::KIC_ED_SLOW && ed_st_reg == kic_pkg::KIC_ED_SLOW)
                   ? held_reg + 1'b1 : '0;
      rep_reg   <= (ed_st_next != kic_pkg::KIC_ED_IDLE && !rep_hit && !fast_hit &&
                    ed_st_reg != kic_pkg::KIC_ED_IDLE) ? rep_reg + 1'b1 : '0; // [R6]
    end
  end

  // ---------------------------------------------------------------
  // Auxiliary inputs
  // ---------------------------------------------------------------
  wire [3:0] aux_in = {aux_input_four, aux_input_three, aux_input_two, aux_input_one};
  logic [3:0] hit_float;
  logic [3:0] hit_setp;
  logic [3:0] hit_dis;
  logic [3:0] hit_lowp;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_aux                               // [R21]
      assign hit_float[gi] = aux_in[gi] && fn_hit(auxcfg_reg[8*gi+:8], `KIC_FN_FLOAT);
      assign hit_setp[gi]  = aux_in[gi] && fn_hit(auxcfg_reg[8*gi+:8], `KIC_FN_SETP2);
      assign hit_dis[gi]   = aux_in[gi] && fn_hit(auxcfg_reg[8*gi+:8], `KIC_FN_SYSDIS);
      assign hit_lowp[gi]  = aux_in[gi] && fn_hit(auxcfg_reg[8*gi+:8], `KIC_FN_LOWP);
    end
  endgenerate

  logic [SW-1:0] ms_reg;
  logic [15:0]   lp_cnt_reg;
  logic          blk_float_reg;
  logic          blk_dis_reg;
  logic          blk_lowp_reg;
  logic          blocked_reg;

  wire lowp_raw = |hit_lowp;
  wire ms_tick  = ms_reg == SW'(MS_CYC - 1);
  wire lp_due   = lp_cnt_reg >= lpdly_reg;                                 // [R20]
  wire blocked_next = blk_float_reg || blk_dis_reg || blk_lowp_reg || err_blk; // [R24]
  wire [3:0] fault_next = blk_float_reg ? `KIC_FLT_FLOAT :                 // [R17]
                          blk_dis_reg   ? `KIC_FLT_SYSDIS :                // [R19]
                          blk_lowp_reg  ? `KIC_FLT_LOWP : `KIC_FLT_NONE;   // [R20]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_reg        <= '0;
      lp_cnt_reg    <= '0;
      blk_float_reg <= 1'b0;
      blk_dis_reg   <= 1'b0;
      blk_lowp_reg  <= 1'b0;
      blocked_reg   <= 1'b0;
    end else begin
      ms_reg        <= ms_tick ? '0 : ms_reg + 1'b1;
      lp_cnt_reg    <= !lowp_raw ? 16'h0000 :
                       (ms_tick && !lp_due) ? lp_cnt_reg + 16'h0001 : lp_cnt_reg;
      blk_float_reg <= |hit_float;                                         // [R17] [R24]
      blk_dis_reg   <= |hit_dis;                                           // [R19] [R24]
      blk_lowp_reg  <= lowp_raw && lp_due;                                 // [R20] [R24]
      blocked_reg   <= blocked_next;
    end
  end

  // ---------------------------------------------------------------
  // Blink generators and lamps
  // ---------------------------------------------------------------
  logic [BW-1:0] bslow_reg;
  logic [BW-1:0] bfast_reg;
  logic          slow_ph_reg;
  logic          fast_ph_reg;

  wire bslow_end = bslow_reg == BW'(BSLOW_CYC - 1);
  wire bfast_end = bfast_reg == BW'(BFAST_CYC - 1);
  wire disabled  = !enable_sw || blk_dis_reg;
  wire comm_next = !comm_cfg ? 1'b0 :                                      // [R15]
                   assoc     ? fast_ph_reg :                               // [R14]
                   !comm_ok  ? slow_ph_reg : 1'b1;                         // [R13] [R12]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bslow_reg        <= '0;
      bfast_reg        <= '0;
      slow_ph_reg      <= 1'b0;
      fast_ph_reg      <= 1'b0;
      led_power        <= 1'b0;
      led_alarm        <= 1'b0;
      led_comm         <= 1'b0;
      relay_output_one <= 1'b0;
      relay_output_two <= 1'b0;
      setpoint_second  <= 1'b0;
      fault_code       <= `KIC_FLT_NONE;
    end else begin
      bslow_reg        <= bslow_end ? '0 : bslow_reg + 1'b1;
      bfast_reg        <= bfast_end ? '0 : bfast_reg + 1'b1;
      slow_ph_reg      <= slow_ph_reg ^ bslow_end;
      fast_ph_reg      <= fast_ph_reg ^ bfast_end;
      led_power        <= disabled ? slow_ph_reg : 1'b1;                   // [R10]
      led_alarm        <= blocked_reg;                                     // [R11] [R24]
      led_comm         <= comm_next;
      relay_output_one <= blocked_reg;                                     // [R21]
      relay_output_two <= pump_run && !blocked_reg;                        // [R22]
      setpoint_second  <= |hit_setp;                                       // [R18]
      fault_code       <= fault_next;
    end
  end

  // ---------------------------------------------------------------
  // Register bus and stored settings
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
    (haddr[7:0] == `KIC_ADDR_CTRL)   ? {25'h0, ctrl_reg} :
    (haddr[7:0] == `KIC_ADDR_AUXCFG) ? auxcfg_reg :
    (haddr[7:0] == `KIC_ADDR_MENU)   ? {20'h0, last_reg, 2'b00, level_reg, cursor_reg} :
    (haddr[7:0] == `KIC_ADDR_PARAM)  ? {16'h0, param_reg} :
    (haddr[7:0] == `KIC_ADDR_STATUS) ? {12'h0, aux_in, 5'h0, relay_output_two,
                                        relay_output_one, led_comm, led_alarm, led_power,
                                        setpoint_second, blocked_reg, fault_code} :
    (haddr[7:0] == `KIC_ADDR_LPDLY)  ? {16'h0, lpdly_reg} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg     <= 1'b0;
      wr_addr_reg     <= 8'h00;
      hrdata_reg      <= 32'h0000_0000;
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      ctrl_reg        <= `KIC_CTRL_RST;
      auxcfg_reg      <= `KIC_AUXCFG_RST;                                  // [R16]
      cursor_reg      <= 4'h0;
      level_reg       <= 2'd0;
      last_reg        <= `KIC_LAST_RST;
      param_reg       <= 16'h0000;
      lpdly_reg       <= `KIC_LPDLY_RST;
      nv_write_strobe <= 1'b0;
      nv_write_data   <= 16'h0000;
    end else begin
      wr_pend_reg     <= ahb_go && hwrite;
      wr_addr_reg     <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
      hreadyout       <= 1'b1;
      hresp           <= 1'b0;
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[6:0];
      end
      if (wr_aux) begin
        auxcfg_reg <= hwdata;                                              // [R16]
      end
      if (wr_menu) begin
        last_reg <= hwdata[11:8];
      end
      if (wr_lpd) begin
        lpdly_reg <= hwdata[15:0];
      end
      cursor_reg      <= cursor_next;
      level_reg       <= level_next;
      if (wr_prm) begin
        param_reg <= hwdata[15:0];
      end else if (do_edit) begin
        param_reg <= prm_step;
      end
      nv_write_strobe <= do_edit && !wr_prm;                               // [R8] [R9]
      nv_write_data   <= (do_edit && !wr_prm) ? prm_step : nv_write_data;  // [R8]
    end
  end

  assign hrdata = hrdata_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Cycles since the last step while fast repeat is active
  logic [RW-1:0] gap_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= (ed_st_reg == kic_pkg::KIC_ED_FAST && !step) ? gap_reg + 1'b1 : '0;
    end
  end

  AST_MODE_FWD: assert property (mode_fwd && !set_exit |=> cursor_reg == $past(cur_inc)) // [R1]
    else $error("mode short press did not advance cursor");
  AST_MODE_BACK: assert property (mode_back && !set_exit |=> cursor_reg == $past(cur_dec)) // [R2]
    else $error("mode hold did not step cursor back");
  AST_SET_EXIT: assert property (set_exit && !wr_menu |=> level_reg == $past(level_reg) - 2'd1) // [R3]
    else $error("set press did not leave menu");
  AST_READONLY: assert property (step && !editable && !wr_prm |=> $stable(param_reg)) // [R4]
    else $error("read-only parameter changed");
  AST_NV_SAVE: assert property (do_edit && !wr_prm |=> nv_write_strobe && nv_write_data == param_reg) // [R8]
    else $error("edited value not saved at once");
  AST_ALARM: assert property (blocked_next |=> ##1 led_alarm) // [R11]
    else $error("alarm lamp not lit while blocked");
  AST_COMM_DARK: assert property (!comm_cfg |=> !led_comm) // [R15]
    else $error("comm lamp lit while not configured");
  AST_COMM_ON: assert property (comm_cfg && comm_ok && !assoc |=> led_comm) // [R12]
    else $error("comm lamp not steady while working");
  AST_RELAY_RUN: assert property (pump_run && !blocked_reg |=> relay_output_two) // [R22]
    else $error("second relay open while running");
  AST_FLOAT: assert property ((|hit_float) |=> blocked_next ##1 fault_code == `KIC_FLT_FLOAT) // [R17]
    else $error("float input did not block with float code");
  AST_FAST_REP: assert property (ed_st_reg == kic_pkg::KIC_ED_FAST |-> gap_reg < RW'(RFAST_CYC)) // [R7]
    else $error("fast repeat step missing");

endmodule

// [kic_user.sv]
`timescale 1ns/1ps
module kic_user (
  input  wire logic       hclk,
  output logic      [3:0] key,
  output logic      [3:0] aux
);
  initial begin
    key = 4'h0;
    aux = 4'h0;
  end
  // Hold one key for n cycles, then let the filter settle
  task automatic press(input int k, input int n);
    @(posedge hclk) key <= key | (4'h1 << k);
    repeat (n) @(posedge hclk);
    key <= key & ~(4'h1 << k);
    repeat (14) @(posedge hclk);
  endtask
  // Set the contacts of the remote unit
  task automatic close(input logic [3:0] v);
    @(posedge hclk) aux <= v;
    repeat (6) @(posedge hclk);
  endtask
endmodule

// [test_kic_panel.sv]
`timescale 1ns/1ps
module test_kic_panel;
  logic hclk = 0, hresetn = 0, hsel, hwrite, hready;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hreadyout, hresp, led_power, led_alarm, led_comm, r1, r2, sp2, nvs;
  logic [3:0] fc, key, aux;
  logic [15:0] nvd;
  int fail_count = 0, tests_run = 0, nv = 0;
  wire [2:0] leds = {led_comm, led_alarm, led_power};
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  always @(posedge hclk) if (nvs === 1'b1) nv++;
  kic_user u (.hclk(hclk), .key(key), .aux(aux));
  kic_panel #(.DEB_CYC(4), .MODE_CYC(40), .FAST_CYC(100), .RSLOW_CYC(20), .RFAST_CYC(5),
    .BSLOW_CYC(8), .BFAST_CYC(3), .MS_CYC(10)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .key_mode(key[0]), .key_set(key[1]), .key_plus(key[2]), .key_minus(key[3]),
    .aux_input_one(aux[0]), .aux_input_two(aux[1]), .aux_input_three(aux[2]),
    .aux_input_four(aux[3]), .led_power(led_power), .led_alarm(led_alarm),
    .led_comm(led_comm), .relay_output_one(r1), .relay_output_two(r2),
    .setpoint_second(sp2), .fault_code(fc), .nv_write_strobe(nvs), .nv_write_data(nvd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= w; hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic blink(input logic [31:0] c, input int s, input int lo, input int hi);
    int t;
    logic [2:0] p;
    t = 0;
    bus(1'b1, 8'h00, c);
    repeat (10) @(posedge hclk);
    p = leds;
    repeat (48) begin
      @(posedge hclk);
      if (leds[s] !== p[s]) t++;
      p = leds;
    end
    tests_run++;
    if (t < lo || t > hi) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, t, lo);
    end
  endtask
  task automatic t_regs;
    bus(1'b0, 8'h00, 0); chk(rd, 32'h0000_0041);
    chk({hreadyout, hresp}, 2'b10);
    bus(1'b0, 8'h04, 0); chk(rd, 32'h0A05_0301);
    bus(1'b0, 8'h18, 0); chk(rd, 32'h0000_0000);
  endtask
  task automatic t_keys;
    u.press(2, 10); bus(1'b0, 8'h0C, 0); chk(rd, 32'h0000_0001);
    chk(nv, 1);
    chk(nvd, 16'h0001);
    u.press(3, 10); bus(1'b0, 8'h0C, 0); chk(rd, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0001); u.press(2, 10); chk(nv, 2);
    bus(1'b1, 8'h00, 32'h0000_0041); u.press(2, 30); chk(nv, 4);
    u.press(2, 200); chk(nv > 16, 1);
    u.press(0, 10); bus(1'b0, 8'h08, 0); chk(rd, 32'h0000_0901);
    u.press(0, 60); bus(1'b0, 8'h08, 0); chk(rd, 32'h0000_0900);
    bus(1'b1, 8'h08, 32'h0000_0910); u.press(0, 10); u.press(1, 10);
    bus(1'b0, 8'h08, 0); chk(rd, 32'h0000_0900);
  endtask
  task automatic t_aux;
    u.close(4'h1); chk({fc, led_alarm, r1}, {4'h1, 2'b11});
    u.close(4'h2); chk({fc, sp2, led_alarm}, {4'h0, 2'b10});
    u.close(4'h4); chk({fc, led_alarm}, {4'h3, 1'b1});
    bus(1'b1, 8'h14, 32'h0000_0002); u.close(4'h8); chk(fc, 4'h0);
    repeat (20) @(posedge hclk); chk(fc, 4'h4);
    u.close(4'h0); chk({fc, led_alarm}, 5'h00);
  endtask
  task automatic t_leds;
    blink(32'h0000_0041, 2, 0, 0); chk(led_comm, 1'b0);
    blink(32'h0000_0047, 2, 0, 0); chk(led_comm, 1'b1);
    blink(32'h0000_0043, 2, 5, 7);
    blink(32'h0000_004B, 2, 14, 17);
    blink(32'h0000_0040, 0, 5, 7);
    blink(32'h0000_0061, 1, 0, 0); chk({led_alarm, led_power}, 2'b11);
    blink(32'h0000_0051, 0, 0, 0); chk({r2, r1}, 2'b10);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    hsel <= 1'b0; hwrite <= 1'b0; htrans <= 2'b00; hsize <= 3'b010;
    haddr <= 32'h0000_0000; hwdata <= 32'h0000_0000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs; t_keys; t_aux; t_leds;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    print_verdict;
  end
endmodule
